/* pmc_pkg.sv */
// constants for the power management clock control block
// assumes a 16-bit register port with a 4-bit word address
package pmc_pkg;
   localparam int          PMC_AW          = 4;
   localparam int          PMC_DW          = 16;
   localparam int          PMC_NMOD_DEF    = 8;
   localparam int          PMC_NMOD_MAX    = 16;
   localparam int          PMC_DIV_W       = 7;

   // register word addresses
   localparam logic [3:0]  PMC_A_CLOCK_DIVIDER_REG    = 4'h0;
   localparam logic [3:0]  PMC_A_WAKECTL   = 4'h1;
   localparam logic [3:0]  PMC_A_MODGATE   = 4'h2;
   localparam logic [3:0]  PMC_A_MODEN     = 4'h3;
   localparam logic [3:0]  PMC_A_MODIDLE   = 4'h4;
   localparam logic [3:0]  PMC_A_IRQSTAT   = 4'h5;
   localparam logic [3:0]  PMC_A_IRQMASK   = 4'h6;
   localparam logic [3:0]  PMC_A_STATE     = 4'h7;

   // clock_divider_reg fields
   localparam int          PMC_B_ROI       = 15;
   localparam int          PMC_B_RATIO_HI  = 14;
   localparam int          PMC_B_RATIO_LO  = 12;
   localparam int          PMC_B_SLOW      = 11;
   localparam logic [15:0] PMC_CLOCK_DIVIDER_REG_MASK = 16'hf800;
   localparam logic [15:0] PMC_CLOCK_DIVIDER_REG_RST  = 16'h0000;

   // wakeup_detector_control fields
   localparam int          PMC_B_WEN       = 15;
   localparam int          PMC_B_WHALT     = 13;
   localparam int          PMC_B_WSINK     = 8;
   localparam logic [15:0] PMC_WAKECTL_MASK = 16'ha100;
   localparam logic [15:0] PMC_WAKECTL_RST = 16'h0000;

   // interrupt status / mask bits
   localparam int          PMC_B_IRQ_WAKE  = 0;
   localparam int          PMC_B_IRQ_ROI   = 1;
   localparam logic [1:0]  PMC_IRQ_RST     = 2'h0;

   // state register bits
   localparam int          PMC_B_ST_SLOW   = 0;
   localparam int          PMC_B_ST_DET    = 1;
   localparam int          PMC_B_ST_SINK   = 2;

   // wake detector states, gray along off -> armed -> fired
   typedef enum logic [1:0] {
      PMC_W_OFF   = 2'h0,
      PMC_W_ARMED = 2'h1,
      PMC_W_FIRED = 2'h3
   } pmc_wstate_t;
endpackage

/* pmc_mod_gate.sv */
// clock and function gating for one peripheral module
// assumes idle_mode is a level from the core, synchronous to clk
`timescale 1ns/10ps
module pmc_mod_gate (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clock_disable,
   input  wire logic function_enable,
   input  wire logic halt_in_idle,
   input  wire logic idle_mode,
   output logic      clk_en,
   output logic      run,
   output logic      reg_access
);
   wire next_clk_en = !clock_disable && !(idle_mode && halt_in_idle);
   wire next_run    = next_clk_en && function_enable;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_en     <= 1'b0;
         run        <= 1'b0;
         reg_access <= 1'b0;
      end else begin
         clk_en     <= next_clk_en;
         run        <= next_run;
         reg_access <= !clock_disable;
      end
   end
endmodule

/* pmc_top.sv */
// doze divider, module gating and slow-discharge wake detector
// assumes a one-cycle strobe register port; all inputs synchronous to clk
`timescale 1ns/10ps
module pmc_top
   import pmc_pkg::*;
#(
   parameter int NMOD = PMC_NMOD_DEF
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic [PMC_AW-1:0] addr,
   input  wire logic [PMC_DW-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [PMC_DW-1:0] rdata,
   input  wire logic              irq_req,
   input  wire logic              idle_mode,
   input  wire logic              sleep_mode,
   input  wire logic              wake_sense_pin,
   output logic                   cpu_clk_en,
   output logic      [NMOD-1:0]   mod_clk_en,
   output logic      [NMOD-1:0]   mod_run,
   output logic      [NMOD-1:0]   mod_reg_access,
   output logic                   wake_req,
   output logic                   discharge_sink_on,
   output logic                   detector_active,
   output logic                   irq
);
   generate
      if (NMOD < 1 || NMOD > PMC_NMOD_MAX) begin : g_bad
         $error("pmc_top: NMOD out of range");
      end
   endgenerate

   logic [15:0]          clock_divider_reg;
   logic [15:0]          wakeup_detector_control;
   logic [NMOD-1:0]      module_clock_gating;
   logic [NMOD-1:0]      module_function_enable;
   logic [NMOD-1:0]      module_halt_in_idle;
   logic [1:0]           irq_status;
   logic [1:0]           irq_mask;
   logic [PMC_DIV_W-1:0] div_cnt;
   pmc_wstate_t          wstate;
   pmc_wstate_t          next_wstate;

   // address decode
   wire wr_clock_divider_reg  = wr_stb && (addr == PMC_A_CLOCK_DIVIDER_REG);
   wire wr_wakectl = wr_stb && (addr == PMC_A_WAKECTL);
   wire wr_modgate = wr_stb && (addr == PMC_A_MODGATE);
   wire wr_moden   = wr_stb && (addr == PMC_A_MODEN);
   wire wr_modidle = wr_stb && (addr == PMC_A_MODIDLE);
   wire wr_irqstat = wr_stb && (addr == PMC_A_IRQSTAT);
   wire wr_irqmask = wr_stb && (addr == PMC_A_IRQMASK);

   // control fields
   wire       full_speed_on_irq          = clock_divider_reg[PMC_B_ROI];
   wire [2:0] doze_ratio                 = clock_divider_reg[PMC_B_RATIO_HI:PMC_B_RATIO_LO];
   wire       slow_cpu_enable            = clock_divider_reg[PMC_B_SLOW];
   wire       wake_detector_enable       = wakeup_detector_control[PMC_B_WEN];
   wire       wake_detector_halt_in_idle = wakeup_detector_control[PMC_B_WHALT];
   wire       discharge_sink_enable      = wakeup_detector_control[PMC_B_WSINK];

   // doze divider: one counter on clk divides only the cpu enable; peripheral enables never use it
   wire                 roi_exit    = full_speed_on_irq && irq_req && slow_cpu_enable;
   wire [PMC_DIV_W-1:0] ratio_mask  = (7'h01 << doze_ratio) - 7'h01;
   wire                 div_wrap    = (div_cnt == ratio_mask);
   wire                 slow_now    = slow_cpu_enable && !roi_exit;
   wire [PMC_DIV_W-1:0] next_div    = (!slow_now || div_wrap) ? 7'h00 : div_cnt + 7'h01;
   wire                 next_cpu_en = !slow_now || div_wrap;

   // clock divider register; an interrupt exit beats a software write
   wire [15:0] clock_divider_reg_wr = wr_clock_divider_reg ? (wdata & PMC_CLOCK_DIVIDER_REG_MASK) : clock_divider_reg;
   wire [15:0] next_clock_divider_reg = roi_exit ? (clock_divider_reg_wr & ~(16'h0001 << PMC_B_SLOW)) : clock_divider_reg_wr;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_divider_reg <= PMC_CLOCK_DIVIDER_REG_RST;
         div_cnt           <= 7'h00;
         cpu_clk_en        <= 1'b0;
      end else begin
         clock_divider_reg <= next_clock_divider_reg;
         div_cnt           <= next_div;
         cpu_clk_en        <= next_cpu_en;
      end
   end

   // module gating control registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         module_clock_gating    <= '0;
         module_function_enable <= '0;
         module_halt_in_idle    <= '0;
      end else begin
         if (wr_modgate) module_clock_gating    <= wdata[NMOD-1:0];
         if (wr_moden)   module_function_enable <= wdata[NMOD-1:0];
         if (wr_modidle) module_halt_in_idle    <= wdata[NMOD-1:0];
      end
   end

   // peripheral clocks ignore doze entirely
   genvar gi;
   generate
      for (gi = 0; gi < NMOD; gi++) begin : g_mod
         pmc_mod_gate u_gate (
            .clk             (clk),
            .arst_n          (arst_n),
            .clock_disable   (module_clock_gating[gi]),
            .function_enable (module_function_enable[gi]),
            .halt_in_idle    (module_halt_in_idle[gi]),
            .idle_mode       (idle_mode),
            .clk_en          (mod_clk_en[gi]),
            .run             (mod_run[gi]),
            .reg_access      (mod_reg_access[gi])
         );
      end
   endgenerate

   // wake detector control; only implemented bits stored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wakeup_detector_control <= PMC_WAKECTL_RST;
      end else if (wr_wakectl) begin
         wakeup_detector_control <= wdata & PMC_WAKECTL_MASK;
      end
   end

   // pin is a synchronous digital level; low means below input-low threshold
   wire det_live  = wake_detector_enable && !(idle_mode && wake_detector_halt_in_idle);
   wire wake_hit  = (wstate == PMC_W_ARMED) && det_live && sleep_mode && !wake_sense_pin;
   wire next_sink = discharge_sink_enable;

   // fired waits for sleep to end so one discharge gives one wakeup
   always_comb begin
      next_wstate = wstate;
      case (wstate)
         PMC_W_OFF: begin
            if (wake_detector_enable) next_wstate = PMC_W_ARMED;
         end
         PMC_W_ARMED: begin
            if (!wake_detector_enable) next_wstate = PMC_W_OFF;
            else if (wake_hit)         next_wstate = PMC_W_FIRED;
         end
         PMC_W_FIRED: begin
            if (!wake_detector_enable) next_wstate = PMC_W_OFF;
            else if (!sleep_mode)      next_wstate = PMC_W_ARMED;
         end
         default: next_wstate = PMC_W_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wstate            <= PMC_W_OFF;
         wake_req          <= 1'b0;
         discharge_sink_on <= 1'b0;
         detector_active   <= 1'b0;
      end else begin
         wstate            <= next_wstate;
         wake_req          <= wake_hit;
         discharge_sink_on <= next_sink;
         detector_active   <= det_live;
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   wire [1:0] irq_set   = {roi_exit, wake_hit};
   wire [1:0] irq_clr   = wr_irqstat ? wdata[1:0] : 2'h0;
   wire [1:0] next_stat = (irq_status & ~irq_clr) | irq_set;
   wire       next_irq  = |(next_stat & irq_mask);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= PMC_IRQ_RST;
         irq_mask   <= PMC_IRQ_RST;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_stat;
         if (wr_irqmask) irq_mask <= wdata[1:0];
         irq        <= next_irq;
      end
   end

   // read mux; unmapped addresses read zero
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      case (addr)
         PMC_A_CLOCK_DIVIDER_REG:  rd_mux = clock_divider_reg;
         PMC_A_WAKECTL: rd_mux = wakeup_detector_control & PMC_WAKECTL_MASK;
         PMC_A_MODGATE: rd_mux[NMOD-1:0] = module_clock_gating;
         PMC_A_MODEN:   rd_mux[NMOD-1:0] = module_function_enable;
         PMC_A_MODIDLE: rd_mux[NMOD-1:0] = module_halt_in_idle;
         PMC_A_IRQSTAT: rd_mux[1:0] = irq_status;
         PMC_A_IRQMASK: rd_mux[1:0] = irq_mask;
         PMC_A_STATE: begin
            rd_mux[PMC_B_ST_SLOW] = slow_cpu_enable;
            rd_mux[PMC_B_ST_DET]  = detector_active;
            rd_mux[PMC_B_ST_SINK] = discharge_sink_on;
         end
         default: rd_mux = 16'h0000;
      endcase
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= rd_stb ? rd_mux : 16'h0000;
      end
   end

   // the charge / sleep sequence is software's job; detector needs enable first

   a_full_rate: assert property (@(posedge clk) disable iff (!arst_n)
      !slow_cpu_enable |=> cpu_clk_en)
      else $error("cpu enable not every cycle at full rate");

   a_doze_gap: assert property (@(posedge clk) disable iff (!arst_n)
      (slow_cpu_enable && !roi_exit && doze_ratio == 3'h1 && cpu_clk_en
       && $stable(clock_divider_reg)) |=> !cpu_clk_en)
      else $error("doze ratio two gave back to back cpu enables");

   a_periph_full: assert property (@(posedge clk) disable iff (!arst_n)
      (slow_cpu_enable && !module_clock_gating[0] && !idle_mode) |=> mod_clk_en[0])
      else $error("peripheral clock slowed by doze");

   a_roi_exit: assert property (@(posedge clk) disable iff (!arst_n)
      roi_exit |=> (!slow_cpu_enable && irq_status[PMC_B_IRQ_ROI]) ##1 cpu_clk_en)
      else $error("interrupt did not restore full speed");

   a_roi_off: assert property (@(posedge clk) disable iff (!arst_n)
      (!full_speed_on_irq && irq_req && slow_cpu_enable && !wr_clock_divider_reg) |=> slow_cpu_enable)
      else $error("interrupt left doze with return disabled");

   a_regs_gated: assert property (@(posedge clk) disable iff (!arst_n)
      module_clock_gating[0] |=> (!mod_reg_access[0] && !mod_clk_en[0] && !mod_run[0]))
      else $error("disabled module still clocked or reachable");

   a_idle_halt: assert property (@(posedge clk) disable iff (!arst_n)
      idle_mode |=> ((mod_clk_en & $past(module_halt_in_idle)) == '0))
      else $error("module kept running in idle while halted");

   a_wake_flag: assert property (@(posedge clk) disable iff (!arst_n)
      wake_hit |=> (wake_req && irq_status[PMC_B_IRQ_WAKE]))
      else $error("wakeup did not set flag");

   a_sink_follow: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_wakectl && wdata[PMC_B_WSINK]) |-> ##2 discharge_sink_on)
      else $error("sink not on after write");

   a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
      (rd_stb && addr == PMC_A_WAKECTL) |=> ((rdata & ~PMC_WAKECTL_MASK) == 16'h0000))
      else $error("unimplemented wake control bit read nonzero");

   a_det_idle: assert property (@(posedge clk) disable iff (!arst_n)
      (idle_mode && wake_detector_halt_in_idle) |=> !detector_active)
      else $error("detector active in idle while halted");
endmodule

/* pmc_wake_pin.sv */
// wake pin network: capacitor charged by software, drained by the sink
// assumes charge and sink_on are sampled on the rising edge of clk
`timescale 1ns/10ps
module pmc_wake_pin #(
   parameter int DECAY = 20
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic charge,
   input  wire logic sink_on,
   output logic      pin
);
   int level;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= 0;
      end else if (charge) begin
         level <= DECAY;
      end else if (sink_on && level > 0) begin
         level <= level - 1;
      end
   end
   // no pull on the node: a drained cap reads below the low threshold
   assign pin = (level != 0);
endmodule

/* tb_pmc_top.sv */
// self-checking bench for the doze, module gating and wake detector block
// assumes the pin network model drives the wake pin; bench drives the rest
`timescale 1ns/10ps
module tb_pmc_top;
   import pmc_pkg::*;
   localparam int NMOD = 8;
   logic              clk        = 1'b0;
   logic              arst_n     = 1'b0;
   logic [PMC_AW-1:0] addr       = 4'h0;
   logic [PMC_DW-1:0] wdata      = 16'h0000;
   logic              wr_stb     = 1'b0;
   logic              rd_stb     = 1'b0;
   logic              irq_req    = 1'b0;
   logic              idle_mode  = 1'b0;
   logic              sleep_mode = 1'b0;
   logic              charge     = 1'b0;
   logic [PMC_DW-1:0] rdata;
   logic              pin;
   logic              cpu_clk_en;
   logic [NMOD-1:0]   mod_clk_en;
   logic [NMOD-1:0]   mod_run;
   logic [NMOD-1:0]   mod_reg_access;
   logic              wake_req;
   logic              sink_on;
   logic              det_act;
   logic              irq;
   int                num_errors = 0;
   int                checks     = 0;
   int                cycles     = 0;

   always #2 clk = ~clk;

   pmc_top #(.NMOD(NMOD)) i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq_req(irq_req),
      .idle_mode(idle_mode), .sleep_mode(sleep_mode), .wake_sense_pin(pin),
      .cpu_clk_en(cpu_clk_en), .mod_clk_en(mod_clk_en), .mod_run(mod_run),
      .mod_reg_access(mod_reg_access), .wake_req(wake_req),
      .discharge_sink_on(sink_on), .detector_active(det_act), .irq(irq));
   pmc_wake_pin i_pin (.clk(clk), .arst_n(arst_n), .charge(charge), .sink_on(sink_on),
      .pin(pin));

   task automatic final_report;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // whole run needs a few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      check(name, rdata, exp);
   endtask

   task automatic pulse_irq;
      @(posedge clk);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
   endtask

   task automatic t_reset;
      check("cpu_clk_en", 16'(cpu_clk_en), 16'h0001);
      check("mod_clk_en", 16'(mod_clk_en), 16'h00ff);
      rdchk("clock_divider_reg", PMC_A_CLOCK_DIVIDER_REG, PMC_CLOCK_DIVIDER_REG_RST);
      rdchk("wakectl", PMC_A_WAKECTL, PMC_WAKECTL_RST);
      for (int a = 2; a < 9; a++) begin
         rdchk("reg", 4'(a), 16'h0000);
      end
   endtask

   task automatic t_doze;
      int cnt;
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'hffff);
      rdchk("clock_divider_reg bits", PMC_A_CLOCK_DIVIDER_REG, PMC_CLOCK_DIVIDER_REG_MASK);
      // doze off restarts the divider before ratios are stepped upward
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'h0000);
      for (int n = 0; n < 8; n++) begin
         cnt = 0;
         wr(PMC_A_CLOCK_DIVIDER_REG, {1'b0, 3'(n), 1'b1, 11'h000});
         tick(2);
         repeat (256) begin
            @(posedge clk);
            #1;
            if (cpu_clk_en === 1'b1) cnt++;
         end
         check("doze pulses", 16'(cnt), 16'(256 >> n));
         check("periph clk", 16'(mod_clk_en), 16'h00ff);
      end
      cnt = 0;
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'h7000);
      tick(2);
      repeat (16) begin
         @(posedge clk);
         #1;
         if (cpu_clk_en === 1'b1) cnt++;
      end
      check("full rate", 16'(cnt), 16'h0010);
   endtask

   task automatic t_roi;
      wr(PMC_A_IRQMASK, 16'h0002);
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'h1800);
      pulse_irq();
      rdchk("no return", PMC_A_CLOCK_DIVIDER_REG, 16'h1800);
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'h9800);
      pulse_irq();
      rdchk("return", PMC_A_CLOCK_DIVIDER_REG, 16'h9000);
      check("cpu full", 16'(cpu_clk_en), 16'h0001);
      rdchk("status", PMC_A_IRQSTAT, 16'h0002);
      check("irq set", 16'(irq), 16'h0001);
      wr(PMC_A_IRQSTAT, 16'h0002);
      tick(2);
      check("irq clear", 16'(irq), 16'h0000);
      wr(PMC_A_CLOCK_DIVIDER_REG, 16'h0000);
   endtask

   task automatic t_gate;
      wr(PMC_A_MODEN, 16'h00fd);
      wr(PMC_A_MODGATE, 16'h0001);
      wr(PMC_A_MODIDLE, 16'h0004);
      @(posedge clk);
      idle_mode <= 1'b1;
      tick(3);
      check("clk_en idle", 16'(mod_clk_en), 16'h00fa);
      check("run", 16'(mod_run), 16'h00f8);
      check("reg access", 16'(mod_reg_access), 16'h00fe);
      @(posedge clk);
      idle_mode <= 1'b0;
      tick(2);
      check("clk_en busy", 16'(mod_clk_en), 16'h00fe);
      wr(PMC_A_MODGATE, 16'hffff);
      rdchk("gate bits", PMC_A_MODGATE, 16'h00ff);
      tick(2);
      check("gated", 16'(mod_clk_en), 16'h0000);
      check("no access", 16'(mod_reg_access), 16'h0000);
      wr(PMC_A_MODGATE, 16'h0000);
      wr(PMC_A_MODIDLE, 16'h0000);
   endtask

   task automatic t_wake;
      int n;
      @(posedge clk);
      charge <= 1'b1;
      tick(30);
      @(posedge clk);
      charge <= 1'b0;
      wr(PMC_A_IRQSTAT, 16'h0003);
      wr(PMC_A_IRQMASK, 16'h0001);
      wr(PMC_A_WAKECTL, 16'h8100);
      tick(2);
      check("active", 16'(det_act), 16'h0001);
      check("sink on", 16'(sink_on), 16'h0001);
      rdchk("state", PMC_A_STATE, 16'h0006);
      @(posedge clk);
      sleep_mode <= 1'b1;
      n = 0;
      while (wake_req !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("wake", 16'(wake_req), 16'h0001);
      check("wake irq", 16'(irq), 16'h0001);
      tick(1);
      check("wake pulse", 16'(wake_req), 16'h0000);
      rdchk("wake flag", PMC_A_IRQSTAT, 16'h0001);
      @(posedge clk);
      sleep_mode <= 1'b0;
      wr(PMC_A_IRQSTAT, 16'h0001);
      wr(PMC_A_WAKECTL, 16'hffff);
      rdchk("wakectl bits", PMC_A_WAKECTL, PMC_WAKECTL_MASK);
      @(posedge clk);
      idle_mode <= 1'b1;
      tick(3);
      check("halt idle", 16'(det_act), 16'h0000);
      @(posedge clk);
      idle_mode <= 1'b0;
      tick(3);
      check("resume", 16'(det_act), 16'h0001);
      wr(PMC_A_WAKECTL, 16'h0100);
      tick(3);
      check("disabled", 16'(det_act), 16'h0000);
      check("sink alone", 16'(sink_on), 16'h0001);
      wr(PMC_A_WAKECTL, 16'h0000);
      tick(3);
      check("sink off", 16'(sink_on), 16'h0000);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      tick(1);
      t_reset();
      t_doze();
      t_roi();
      t_gate();
      t_wake();
      final_report();
   end
endmodule
